//--- design/bwc_bus_width_control.sv
// Purpose: Bus width control register with timer access gate, APB slave
// Assumes: All inputs but rst synchronous to sys_clk (rst acts asynchronously); mode pins held steady in normal use
// Notes:   Region width outputs lag a register write by one cycle
//
// Chosen here: the APB interface to the registers and the register offsets.

`timescale 1ns/1ps
`default_nettype none

module bwc_bus_width_control
(
   input  wire logic                                 sys_clk,
   input  wire logic                                 rst,
   input  wire logic                                 psel,
   input  wire logic                                 penable,
   input  wire logic                                 pwrite,
   input  wire logic [bwc_pkg::ADDR_WIDTH-1:0]       paddr,
   input  wire logic [31:0]                          pwdata,
   input  wire logic [3:0]                           pstrb,
   output logic      [31:0]                          prdata,
   output logic                                      pready,
   output logic                                      pslverr,
   input  wire logic                                 rom_enabled,
   input  wire logic                                 reduced_pin_variant,
   input  wire logic                                 mode_wide,
   output logic                                      timer_reg_access_gate,
   output bwc_pkg::bwc_widths_type                   region_widths
);

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // State

   bwc_pkg::bwc_state_type s;
   bwc_pkg::bwc_state_type next_s;

   logic        setup_phase;
   logic        access_done;
   logic        addr_hit;
   logic [3:0]  eff_longword;
   logic [15:0] read_image;

   assign setup_phase = psel && !penable;
   assign access_done = psel && penable && s.pready;
   assign addr_hit    = (paddr == bwc_pkg::BUS_WIDTH_CONTROL_OFFSET);

   // Longword bits do not exist on the reduced-pin variant
   assign eff_longword = reduced_pin_variant ? 4'h0 : s.longword;

   // Reserved bits are constants, never storage, so a write cannot reach them
   assign read_image = {1'b0,
                        bwc_pkg::RSVD_ONE_VALUE,
                        s.timer_gate,
                        5'h00,
                        eff_longword,
                        s.size};

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb
   begin
      next_s = s;

      // Answer one cycle after setup; pready is a flop so the access phase lasts one cycle
      next_s.pready  = setup_phase;
      next_s.pslverr = setup_phase && !addr_hit;
      next_s.prdata  = 32'h0000_0000;
      if (setup_phase && addr_hit && !pwrite)
      begin
         next_s.prdata = {16'h0000, read_image};
      end

      // Write lands at the completing edge, per byte lane
      if (access_done && pwrite && addr_hit)
      begin
         if (pstrb[bwc_pkg::STRB_HIGH_LANE])
         begin
            next_s.timer_gate = pwdata[bwc_pkg::TIMER_GATE_BIT];
         end
         if (pstrb[bwc_pkg::STRB_LOW_LANE])
         begin
            next_s.size = pwdata[bwc_pkg::SIZE_LSB +: 4];
            if (reduced_pin_variant)
            begin
               next_s.longword = 4'h0;
            end
            else
            begin
               next_s.longword = pwdata[bwc_pkg::LONGWORD_LSB +: 4];
            end
         end
      end

      // Longword wins over size; region 0/4 falls back to the mode pin without ROM
      for (int i = 0; i < bwc_pkg::NUM_REGION_PAIRS; i++)
      begin
         if ((i == 0) && !rom_enabled)
         begin
            if (reduced_pin_variant)
            begin
               next_s.widths[i] = mode_wide ? bwc_pkg::WIDTH_16 : bwc_pkg::WIDTH_8;
            end
            else
            begin
               next_s.widths[i] = mode_wide ? bwc_pkg::WIDTH_32 : bwc_pkg::WIDTH_16;
            end
         end
         else if (eff_longword[i])
         begin
            next_s.widths[i] = bwc_pkg::WIDTH_32;
         end
         else if (s.size[i])
         begin
            next_s.widths[i] = bwc_pkg::WIDTH_16;
         end
         else
         begin
            next_s.widths[i] = bwc_pkg::WIDTH_8;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         s <= bwc_pkg::RESET_STATE;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign prdata                = s.prdata;
   assign pready                = s.pready;
   assign pslverr               = s.pslverr;
   assign timer_reg_access_gate = s.timer_gate;
   assign region_widths         = s.widths;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge sys_clk);
   endclocking

   default disable iff (rst);

   // Read completions of the mapped register
   sequence read_done_s;
      pready && !pslverr && !$past(pwrite) && $past(psel);
   endsequence

   a_bit15_reads_zero: assert property (
      read_done_s |-> prdata[bwc_pkg::RSVD_ZERO_HIGH_BIT] == 1'b0)
      else $error("Bit 15 read back as one");

   a_bit14_reads_one: assert property (
      read_done_s |-> prdata[bwc_pkg::RSVD_ONE_BIT] == bwc_pkg::RSVD_ONE_VALUE)
      else $error("Bit 14 read back as zero");

   a_mid_reads_zero: assert property (
      read_done_s |-> prdata[bwc_pkg::RSVD_MID_MSB:bwc_pkg::RSVD_MID_LSB] == 5'h00)
      else $error("Bits 12 to 8 read back nonzero");

   a_upper_reads_zero: assert property (read_done_s |-> prdata[31:16] == 16'h0000)
      else $error("Upper half of read data nonzero");

   a_gate_follows_write: assert property (
      access_done && pwrite && addr_hit && pstrb[1]
      |=> timer_reg_access_gate == $past(pwdata[13]))
      else $error("Timer access gate did not take the written value");

   a_gate_read_match: assert property (read_done_s |-> prdata[13] == $past(s.timer_gate))
      else $error("Timer access gate read back wrong");

   a_reduced_no_long: assert property (
      read_done_s and $past(reduced_pin_variant) |-> prdata[7:4] == 4'h0)
      else $error("Longword bits visible on reduced-pin variant");

   a_rom_off_mode: assert property (
      !rom_enabled && !reduced_pin_variant && mode_wide [*2]
      |-> region_widths[0] == bwc_pkg::WIDTH_32)
      else $error("Region 0 width ignores the mode pin");

   a_rom_off_narrow: assert property (
      !rom_enabled && reduced_pin_variant && !mode_wide [*2]
      |-> region_widths[0] == bwc_pkg::WIDTH_8)
      else $error("Region 0 width ignores the mode pin on reduced variant");

   a_long_beats_size: assert property (
      $past(eff_longword[3]) && !$past(rst) |-> region_widths[3] == bwc_pkg::WIDTH_32)
      else $error("Region 3 longword select did not give 32 bits");

   a_size3_select: assert property (
      !$past(eff_longword[3]) && !$past(rst)
      |-> region_widths[3] == ($past(s.size[3]) ? bwc_pkg::WIDTH_16 : bwc_pkg::WIDTH_8))
      else $error("Region 3 size select gave wrong width");

   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("Ready held longer than one cycle");

   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("No answer one cycle after setup");

   a_unmapped_error: assert property (
      psel && !penable && !addr_hit |=> pslverr && prdata == 32'h0000_0000)
      else $error("Unmapped access not flagged");

   a_reset_image: assert property (
      $fell(rst) |-> s.timer_gate == bwc_pkg::RESET_TIMER_GATE && s.longword == bwc_pkg::RESET_LONGWORD
                     && s.size == bwc_pkg::RESET_SIZE)
      else $error("Reset image wrong");

   generate
      for (genvar g = 1; g < bwc_pkg::NUM_REGION_PAIRS; g++)
      begin : g_region
         a_region_long: assert property (
            $past(eff_longword[g]) && !$past(rst) |-> region_widths[g] == bwc_pkg::WIDTH_32)
            else $error("Longword select did not give 32 bits");

         a_region_size: assert property (
            !$past(eff_longword[g]) && !$past(rst)
            |-> region_widths[g] == ($past(s.size[g]) ? bwc_pkg::WIDTH_16 : bwc_pkg::WIDTH_8))
            else $error("Size select gave wrong width");
      end
   endgenerate

   a_region0_long: assert property (
      $past(eff_longword[0]) && $past(rom_enabled) && !$past(rst)
      |-> region_widths[0] == bwc_pkg::WIDTH_32)
      else $error("Region 0 longword select did not give 32 bits");

   a_region0_size: assert property (
      !$past(eff_longword[0]) && $past(rom_enabled) && !$past(rst)
      |-> region_widths[0] == ($past(s.size[0]) ? bwc_pkg::WIDTH_16 : bwc_pkg::WIDTH_8))
      else $error("Region 0 size select gave wrong width");

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Write path, bus reply and region width checks

   a_idle_quiet: assert property (!pready |-> prdata == 32'h0000_0000 && !pslverr)
      else $error("Reply lines not quiet outside the access phase");

   a_write_reply_zero: assert property (pready && $past(pwrite) |-> prdata == 32'h0000_0000)
      else $error("Write reply carried read data");

   a_ready_from_setup: assert property (pready |-> $past(psel) && !$past(penable))
      else $error("Ready without a setup cycle before it");

   a_error_on_miss: assert property (
      pslverr |-> pready && $past(paddr) != bwc_pkg::BUS_WIDTH_CONTROL_OFFSET)
      else $error("Error reply for the mapped word");

   a_long_read_match: assert property (
      read_done_s |-> prdata[bwc_pkg::LONGWORD_LSB +: 4] == $past(eff_longword))
      else $error("Longword bits read back wrong");

   a_size_read_match: assert property (
      read_done_s |-> prdata[bwc_pkg::SIZE_LSB +: 4] == $past(s.size))
      else $error("Size bits read back wrong");

   // Reserved bits are not storage, so only a mapped, strobed write may move the state
   a_no_stray_write: assert property (
      access_done && !(pwrite && addr_hit)
      |=> $stable(s.timer_gate) && $stable(s.longword) && $stable(s.size))
      else $error("State changed without a mapped write");

   a_high_lane_hold: assert property (
      access_done && pwrite && addr_hit && !pstrb[bwc_pkg::STRB_HIGH_LANE]
      |=> $stable(s.timer_gate))
      else $error("Timer access gate moved without its byte strobe");

   a_low_lane_hold: assert property (
      access_done && pwrite && addr_hit && !pstrb[bwc_pkg::STRB_LOW_LANE]
      |=> $stable(s.longword) && $stable(s.size))
      else $error("Width fields moved without their byte strobe");

   a_size_follows_write: assert property (
      access_done && pwrite && addr_hit && pstrb[bwc_pkg::STRB_LOW_LANE]
      |=> s.size == $past(pwdata[bwc_pkg::SIZE_LSB +: 4]))
      else $error("Size bits did not take the written value");

   a_long_follows_write: assert property (
      access_done && pwrite && addr_hit && pstrb[bwc_pkg::STRB_LOW_LANE] && !reduced_pin_variant
      |=> s.longword == $past(pwdata[bwc_pkg::LONGWORD_LSB +: 4]))
      else $error("Longword bits did not take the written value");

   a_reduced_long_clear: assert property (
      access_done && pwrite && addr_hit && pstrb[bwc_pkg::STRB_LOW_LANE] && reduced_pin_variant
      |=> s.longword == 4'h0)
      else $error("Longword bits stored on reduced-pin variant");

   a_rom_off_default: assert property (
      (!rom_enabled && !reduced_pin_variant && !mode_wide) [*2]
      |-> region_widths[0] == bwc_pkg::WIDTH_16)
      else $error("Region 0 width ignores the low mode pin");

   a_rom_off_reduced_wide: assert property (
      (!rom_enabled && reduced_pin_variant && mode_wide) [*2]
      |-> region_widths[0] == bwc_pkg::WIDTH_16)
      else $error("Region 0 width ignores the mode pin on reduced variant");

   generate
      for (genvar p = 0; p < bwc_pkg::NUM_REGION_PAIRS; p++)
      begin : g_pair
         a_width_code_legal: assert property (region_widths[p] != 2'h3)
            else $error("Region width holds an unused code");

         // Mode pin never asks for 32 bits on this variant and longword bits are forced to zero, so no pair may reach it
         a_reduced_narrow: assert property (
            $past(reduced_pin_variant) && !$past(rst) |-> region_widths[p] != bwc_pkg::WIDTH_32)
            else $error("32-bit width on reduced-pin variant");
      end
   endgenerate

   c_write_reg: cover property (access_done && pwrite && addr_hit);

   c_read_reg: cover property (read_done_s);

   c_unmapped: cover property (pready && pslverr);

   c_long_region3: cover property (region_widths[3] == bwc_pkg::WIDTH_32);

   c_rom_off_region0: cover property (!rom_enabled && region_widths[0] == bwc_pkg::WIDTH_32);

endmodule : bwc_bus_width_control

`default_nettype wire

//--- pkg/bwc_pkg.sv
// Purpose: Constants and types for the bus width control register block
// Assumes: APB slave with 32-bit data, one register word
// Notes:   Width codes are shared with the external bus cycle logic

`default_nettype none

package bwc_pkg;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Address map
   localparam logic [11:0] BUS_WIDTH_CONTROL_OFFSET = 12'h000;
   localparam int          ADDR_WIDTH               = 12;
   localparam int          NUM_REGION_PAIRS         = 4;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int RSVD_ZERO_HIGH_BIT = 15;
   localparam int RSVD_ONE_BIT       = 14;
   localparam int TIMER_GATE_BIT     = 13;
   localparam int RSVD_MID_MSB       = 12;
   localparam int RSVD_MID_LSB       = 8;
   localparam int LONGWORD_LSB       = 4;
   localparam int SIZE_LSB           = 0;
   localparam int STRB_LOW_LANE      = 0;
   localparam int STRB_HIGH_LANE     = 1;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Reset values and the fixed value of bit 14
   localparam logic       RESET_TIMER_GATE = 1'h1;
   localparam logic [3:0] RESET_LONGWORD   = 4'h0;
   localparam logic [3:0] RESET_SIZE       = 4'hf;
   localparam logic       RSVD_ONE_VALUE   = 1'h1;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Bus width codes
   localparam logic [1:0] WIDTH_8  = 2'h0;
   localparam logic [1:0] WIDTH_16 = 2'h1;
   localparam logic [1:0] WIDTH_32 = 2'h2;

   typedef logic [NUM_REGION_PAIRS-1:0][1:0] bwc_widths_type;

   typedef struct packed {
      logic                        timer_gate;
      logic [NUM_REGION_PAIRS-1:0] longword;
      logic [NUM_REGION_PAIRS-1:0] size;
      bwc_widths_type              widths;
      logic                        pready;
      logic                        pslverr;
      logic [31:0]                 prdata;
   } bwc_state_type;

   localparam bwc_state_type RESET_STATE = '{
      timer_gate : RESET_TIMER_GATE,
      longword   : RESET_LONGWORD,
      size       : RESET_SIZE,
      widths     : {NUM_REGION_PAIRS{WIDTH_16}},
      pready     : 1'h0,
      pslverr    : 1'h0,
      prdata     : 32'h0000_0000
   };

endpackage : bwc_pkg

`default_nettype wire

//--- testbench/tb_bus_size_control_register.sv
// Purpose: Self-checking bench for the bus width control register block
// Assumes: APB answer one cycle after setup; region widths lag a write by one edge
// Notes:   Table rows hold write data beside the read-back that should follow
`timescale 1ns/1ps
`default_nettype none
module tb_bus_size_control_register;
   logic                              sys_clk             = 1'h0;
   logic                              rst                 = 1'h1;
   logic                              psel                = 1'h0;
   logic                              penable             = 1'h0;
   logic                              pwrite              = 1'h0;
   logic [bwc_pkg::ADDR_WIDTH-1:0]    paddr               = 12'h000;
   logic [31:0]                       pwdata              = 32'h0000_0000;
   logic [3:0]                        pstrb               = 4'hf;
   logic                              rom_enabled         = 1'h1;
   logic                              reduced_pin_variant = 1'h0;
   logic                              mode_wide           = 1'h0;
   logic [31:0]                       prdata;
   logic                              pready;
   logic                              pslverr;
   logic                              timer_reg_access_gate;
   bwc_pkg::bwc_widths_type           region_widths;
   int                                failures            = 0;
   int                                total_checks        = 0;
   logic [31:0]                       rd;
   logic                              err;
   logic [31:0]                       row_wr [4] = '{32'hffff_ffff, 32'h0000_0000, 32'h0000_00a5, 32'h0000_2058};
   logic [31:0]                       row_rd [4] = '{32'h0000_60ff, 32'h0000_4000, 32'h0000_40a5, 32'h0000_6058};

   always #20 sys_clk = ~sys_clk;

   bwc_bus_width_control i_bwc_bus_width_control (
      .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rom_enabled(rom_enabled), .reduced_pin_variant(reduced_pin_variant), .mode_wide(mode_wide),
      .timer_reg_access_gate(timer_reg_access_gate), .region_widths(region_widths));

   ////////////////////////////////////////////////////////////////////////////////////////////////
   task results;
      $display("Checks %0d, failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : results

   task check_reg(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_reg

   task check_widths(input bwc_pkg::bwc_widths_type got, input bwc_pkg::bwc_widths_type exp);
      total_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_widths

   // Expected widths from a register image and the current pins; kept apart from the design
   function automatic bwc_pkg::bwc_widths_type exp_w(input logic [31:0] r);
      bwc_pkg::bwc_widths_type w;
      for (int i = 0; i < 4; i++)
         w[i] = (r[4+i] && !reduced_pin_variant) ? bwc_pkg::WIDTH_32 :
                (r[i] ? bwc_pkg::WIDTH_16 : bwc_pkg::WIDTH_8);
      if (!rom_enabled)
         w[0] = reduced_pin_variant ? (mode_wide ? bwc_pkg::WIDTH_16 : bwc_pkg::WIDTH_8) :
                                      (mode_wide ? bwc_pkg::WIDTH_32 : bwc_pkg::WIDTH_16);
      return w;
   endfunction : exp_w

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // One APB transfer; the wait is bounded so a silent slave cannot hang the run
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      @(posedge sys_clk);
      psel    <= 1'h1;
      penable <= 1'h0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      @(posedge sys_clk);
      penable <= 1'h1;
      n = 0;
      do
      begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      if (pready !== 1'h1)
      begin
         failures++;
         results();
      end
      rd  = prdata;
      err = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask : apb

   // Widths are final one edge after the write edge; two edges here are enough
   task settle;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask : settle

   task read_check(input logic [31:0] exp);
      apb(1'h0, bwc_pkg::BUS_WIDTH_CONTROL_OFFSET, 32'h0000_0000, 4'hf);
      check_reg(rd, exp);
      check_reg({31'h0, err}, 32'h0000_0000);
      settle();
      check_widths(region_widths, exp_w(exp));
      check_reg({31'h0, timer_reg_access_gate}, {31'h0, exp[13]});
      @(posedge sys_clk);
   endtask : read_check

   ////////////////////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (2) @(posedge sys_clk);
      #1;
      check_reg({prdata[31:1], timer_reg_access_gate}, 32'h0000_0001);
      check_widths(region_widths, {4{bwc_pkg::WIDTH_16}});
      @(posedge sys_clk);
      rst <= 1'h0;
      read_check(32'h0000_600f);
      for (int i = 0; i < 4; i++)
      begin
         apb(1'h1, bwc_pkg::BUS_WIDTH_CONTROL_OFFSET, row_wr[i], 4'hf);
         read_check(row_rd[i]);
      end
      // Unmapped word: error reply, zero data, register untouched
      apb(1'h1, 12'h004, 32'h0000_0000, 4'hf);
      check_reg({31'h0, err}, 32'h0000_0001);
      apb(1'h0, 12'h004, 32'h0000_0000, 4'hf);
      check_reg({rd[31:1], err}, 32'h0000_0001);
      // Upper lanes carry nothing
      apb(1'h1, bwc_pkg::BUS_WIDTH_CONTROL_OFFSET, 32'hffff_ffff, 4'hc);
      read_check(32'h0000_6058);
      // Low lane only: gate keeps its value
      apb(1'h1, bwc_pkg::BUS_WIDTH_CONTROL_OFFSET, 32'h0000_0000, 4'h1);
      read_check(32'h0000_6000);
      // High lane only: width fields keep their value
      apb(1'h1, bwc_pkg::BUS_WIDTH_CONTROL_OFFSET, 32'h0000_00ff, 4'h2);
      read_check(32'h0000_4000);
      // ROM off: pair 0 follows the mode pin whatever its longword bit says
      apb(1'h1, bwc_pkg::BUS_WIDTH_CONTROL_OFFSET, 32'h0000_201f, 4'hf);
      rom_enabled <= 1'h0;
      read_check(32'h0000_601f);
      mode_wide <= 1'h1;
      read_check(32'h0000_601f);
      // Reduced-pin variant: longword bits cannot be set
      rom_enabled         <= 1'h1;
      reduced_pin_variant <= 1'h1;
      apb(1'h1, bwc_pkg::BUS_WIDTH_CONTROL_OFFSET, 32'h0000_20ff, 4'hf);
      read_check(32'h0000_600f);
      rom_enabled <= 1'h0;
      read_check(32'h0000_600f);
      mode_wide <= 1'h0;
      apb(1'h1, bwc_pkg::BUS_WIDTH_CONTROL_OFFSET, 32'h0000_0000, 4'hf);
      read_check(32'h0000_4000);
      // Second reset mid-run restores the full image
      rom_enabled         <= 1'h1;
      reduced_pin_variant <= 1'h0;
      rst                 <= 1'h1;
      repeat (2) @(posedge sys_clk);
      #1;
      check_reg({prdata[31:1], timer_reg_access_gate}, 32'h0000_0001);
      check_widths(region_widths, {4{bwc_pkg::WIDTH_16}});
      @(posedge sys_clk);
      rst <= 1'h0;
      read_check(32'h0000_600f);
      // One-time setup after the second reset, with no region written before it
      apb(1'h1, bwc_pkg::BUS_WIDTH_CONTROL_OFFSET, 32'h0000_20a5, 4'hf);
      read_check(32'h0000_60a5);
      results();
   end
endmodule : tb_bus_size_control_register
`default_nettype wire
